// file: hdl/dma_pkg.sv
// Shared constants and carrier types for the packet DMA controller
package dma_pkg;

    // ------------------------------------------------------------------
    // Geometry
    // ------------------------------------------------------------------
    localparam int          NUM_CH      = 4;
    localparam int          QUEUE_DEPTH = 16;
    localparam int          PKT_W       = 5;
    localparam logic [4:0]  QUEUE_FULL  = 5'h10;

    // ------------------------------------------------------------------
    // Register map, byte offsets from the controller base
    // ------------------------------------------------------------------
    localparam logic [15:0] CTRL_BASE   = 16'h4000;
    localparam logic [3:0]  OFS_CH_LAST = 4'h7;
    localparam logic [3:0]  OFS_CMD     = 4'h8;
    localparam logic [3:0]  OFS_REQ     = 4'h9;
    localparam logic [3:0]  OFS_MASK    = 4'hA;
    localparam logic [3:0]  OFS_MODE    = 4'hB;
    localparam logic [3:0]  OFS_CLR_FF  = 4'hC;

    // ------------------------------------------------------------------
    // Field positions and encodings
    // ------------------------------------------------------------------
    localparam int          CMD_M2M_BIT = 0;
    localparam int          REQ_SET_BIT = 2;
    localparam int          MODE_TYPE_LSB = 2;
    localparam int          MODE_SEL_LSB  = 6;
    localparam logic [1:0]  TYPE_VERIFY = 2'h0;
    localparam logic [1:0]  TYPE_WRITE  = 2'h1;
    localparam logic [1:0]  TYPE_READ   = 2'h2;
    localparam logic [1:0]  SEL_DEMAND  = 2'h0;
    localparam logic [1:0]  SEL_SINGLE  = 2'h1;
    localparam logic [1:0]  SEL_BLOCK   = 2'h2;

    // ------------------------------------------------------------------
    // Packet layout and reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  HDR_BYTES   = 8'h08;
    localparam logic [9:0]  MAX_PAYLOAD = 10'h3F8;
    localparam logic [3:0]  RST_MASK    = 4'hF;
    localparam logic [3:0]  RST_DONE    = 4'hF;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_DEV     = 6'h02,
        ST_M2M_RD  = 6'h04,
        ST_M2M_WR  = 6'h08,
        ST_SG_LOAD = 6'h10,
        ST_PIO     = 6'h20
    } state_e;

    typedef struct packed {
        logic [15:0] addr;
        logic        rd;
        logic        wr;
        logic [7:0]  wdata;
        logic [3:0]  dack;
        logic        tc;
    } mem_cycle_s;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } reg_req_s;

    typedef struct packed {
        logic        push;
        logic [1:0]  ch;
        logic [4:0]  pkt;
    } sg_push_s;

    typedef struct packed {
        logic        req;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } pio_req_s;

    typedef struct packed {
        state_e           st;
        logic [3:0][15:0] addr;
        logic [3:0][15:0] cnt;
        logic [3:0][7:0]  mode;
        logic [3:0]       mask;
        logic [3:0]       sreq;
        logic [3:0]       blk;
        logic [3:0]       done;
        logic [3:0]       tc;
        logic             m2m;
        logic             ff;
        logic [7:0]       rdata;
        mem_cycle_s       cyc;
        logic [3:0][3:0]  wp;
        logic [3:0][3:0]  rp;
        logic [3:0][4:0]  qn;
        logic [3:0][14:0] ext;
        logic [1:0]       ld_ch;
        logic             pio_ack;
        logic [7:0]       pio_rdata;
        logic [3:0]       dsync1;
        logic [3:0]       dsync2;
    } dma_state_s;

endpackage

// file: hdl/packet_isa_dma_controller.sv
// Four channel packet and bus DMA controller with packet queues
//----------------------------------------------------------------------
// What this block does
// [R1] Count register holds bytes minus one
// [R2] Payload per packet capped at 1016 bytes
// [R3] Packet transfers start at byte offset 8
// [R4] Address MSB plus packet number selects slot
// [R5] Channel registers consecutive from base 0x4000
// [R6] Cleared byte pointer: low byte first
// [R7] Byte pointer toggles on each byte access
// [R8] One mode write programs a whole channel
// [R9] Status read clears stale terminal counts
// [R10] Shadow output mirrors every terminal count
// [R11] Software masks channel while programming it
// [R12] Software acquires bus and sets window
// [R13] No cycles while microcontroller holds bus, except the write half of a copy already begun
// [R14] Command write with bit clear: device mode
// [R15] Only channels 2, 3 reach external memory, except in mem-to-mem copies on channels 0, 1
// [R16] External transfers stay in low 32 KB
// [R17] Mem-to-mem: channel 0 source, 1 destination
// [R18] Channel 1 count and terminal count govern
// [R19] Software request on channel 0 starts copy
// [R20] Four channels, sixteen queued packets each
// [R21] Queued packets run with no software help, except that channel 0 runs only its first queued copy
// [R22] Programmed cycles steal gaps between transfers
// [R23] Queued copy: packet and external memory only
// [R24] Memory operation bit picks external memory
// [R25] Status terminal count bits clear on read
// [R26] Shadow reads never clear anything
// [R27] Count past zero: terminal count, stop
//----------------------------------------------------------------------
`timescale 1ns/1ps
module packet_isa_dma_controller (
    // Clock and reset
    input  wire logic                sys_clk,
    input  wire logic                sys_rst,
    // Register port
    input  wire dma_pkg::reg_req_s   reg_req,
    output logic [7:0]               reg_rdata,
    // Bus ownership and device requests
    input  wire logic                bus_hold,
    input  wire logic [3:0]          dreq,
    // Memory and device cycles
    output dma_pkg::mem_cycle_s      mem_cyc,
    input  wire logic [7:0]          mem_rdata,
    // Terminal count shadow
    output logic [3:0]               bus_stat_tc,
    // Scatter/gather queues
    input  wire dma_pkg::sg_push_s   sg_push,
    input  wire logic [3:0]          sg_enable,
    input  wire logic [3:0]          sg_memory_operation_bit,
    input  wire logic [14:0]         sg_ext_addr,
    input  wire logic [9:0]          sg_size,
    output logic [3:0]               sg_full,
    // Programmed I/O engine
    input  wire dma_pkg::pio_req_s   pio_req,
    output logic                     pio_ack,
    output logic [7:0]               pio_rdata
);
    import dma_pkg::*;

    //------------------------------------------------------------------
    // State
    //------------------------------------------------------------------
    dma_state_s q;
    dma_state_s d;
    logic       hit;
    logic [3:0] ofs;
    logic [3:0] tc_set;
    logic       q_wr;
    logic [5:0] q_waddr;
    logic       q_rd;
    logic [5:0] q_raddr;
    logic [4:0] q_rdata;

    assign hit = reg_req.addr[15:4] == CTRL_BASE[15:4];
    assign ofs = reg_req.addr[3:0];

    always_comb begin
        logic       found;
        logic [1:0] c;
        logic [1:0] ty;
        logic [9:0] sz;
        logic [15:0] pa;
        logic [15:0] ea;
        found = 1'b0;
        c = 2'h0;
        ty = 2'h0;
        sz = 10'h000;
        pa = 16'h0000;
        ea = 16'h0000;
        d = q;
        tc_set = 4'h0;
        q_wr = 1'b0;
        q_waddr = 6'h00;
        q_rd = 1'b0;
        q_raddr = 6'h00;
        d.cyc = '0;
        d.pio_ack = 1'b0;
        d.dsync1 = dreq;
        d.dsync2 = q.dsync1;

        //--------------------------------------------------------------
        // Register writes
        //--------------------------------------------------------------
        if (hit && reg_req.wr) begin
            if (ofs <= OFS_CH_LAST) begin
                // [R5] consecutive channel pairs
                c = ofs[2:1];
                // [R6] [R7] pointer steers and toggles
                d.ff = ~q.ff;
                if (ofs[0]) begin
                    if (q.ff) d.cnt[c][15:8] = reg_req.wdata;
                    else d.cnt[c][7:0] = reg_req.wdata;
                    d.done[c] = 1'b0;
                end else begin
                    if (q.ff) d.addr[c][15:8] = reg_req.wdata;
                    else d.addr[c][7:0] = reg_req.wdata;
                end
            end
            case (ofs)
                // [R14] clear bit returns device mode
                OFS_CMD:    d.m2m = reg_req.wdata[CMD_M2M_BIT];
                OFS_REQ:    d.sreq[reg_req.wdata[1:0]] =
                                reg_req.wdata[REQ_SET_BIT];
                OFS_MASK:   d.mask[reg_req.wdata[1:0]] =
                                reg_req.wdata[REQ_SET_BIT];
                // [R8] whole channel mode in one byte
                OFS_MODE:   d.mode[reg_req.wdata[1:0]] = reg_req.wdata;
                OFS_CLR_FF: d.ff = 1'b0;
                default:    ;
            endcase
        end

        //--------------------------------------------------------------
        // Register reads
        //--------------------------------------------------------------
        if (hit && reg_req.rd) begin
            d.rdata = 8'h00;
            if (ofs <= OFS_CH_LAST) begin
                c = ofs[2:1];
                d.ff = ~q.ff;
                pa = ofs[0] ? q.cnt[c] : q.addr[c];
                d.rdata = q.ff ? pa[15:8] : pa[7:0];
            end else if (ofs == OFS_CMD) begin
                d.rdata = {q.sreq, q.tc};
                // [R9] [R25] destructive read
                d.tc = 4'h0;
            end
        end

        //--------------------------------------------------------------
        // Queue push
        //--------------------------------------------------------------
        // [R20] sixteen deep per channel, full drops
        if (sg_push.push && q.qn[sg_push.ch] != QUEUE_FULL) begin
            q_wr = 1'b1;
            q_waddr = {sg_push.ch, q.wp[sg_push.ch]};
            d.wp[sg_push.ch] = q.wp[sg_push.ch] + 4'h1;
            d.qn[sg_push.ch] = q.qn[sg_push.ch] + 5'h01;
        end
        for (int i = 0; i < NUM_CH; i++) begin
            if (!sg_enable[i]) d.ext[i] = sg_ext_addr;
        end

        //--------------------------------------------------------------
        // Transfer engine
        //--------------------------------------------------------------
        case (q.st)
            ST_IDLE: begin
                for (int i = 0; i < NUM_CH; i++) begin
                    if (!found && !q.mask[i] && !q.done[i] &&
                        (q.dsync2[i] || q.sreq[i] || q.blk[i]) &&
                        !(q.m2m && i < 2)) begin
                        found = 1'b1;
                        c = 2'(i);
                    end
                end
                // [R13] no bus cycle starts while bus is held
                if (bus_hold) begin
                    found = 1'b0;
                end else if (pio_req.req && !q.pio_ack) begin
                    // [R22] programmed cycle in a gap
                    d.cyc.addr = pio_req.addr;
                    d.cyc.wr = pio_req.wr;
                    d.cyc.rd = ~pio_req.wr;
                    d.cyc.wdata = pio_req.wdata;
                    d.st = ST_PIO;
                    found = 1'b0;
                end else if (q.m2m && q.sreq[0] && !q.done[1]) begin
                    // [R17] [R19] read source on channel 0
                    d.cyc.addr = q.addr[0];
                    d.cyc.rd = 1'b1;
                    d.addr[0] = q.addr[0] + 16'h0001;
                    d.st = ST_M2M_RD;
                    found = 1'b0;
                end
                if (found) begin
                    ty = q.mode[c][MODE_TYPE_LSB +: 2];
                    // [R15] low channels kept in packet memory
                    d.cyc.addr = (c < 2'h2) ?
                        {1'b1, q.addr[c][14:0]} : q.addr[c];
                    d.cyc.rd = ty == TYPE_READ;
                    d.cyc.wr = ty == TYPE_WRITE;
                    d.cyc.dack[c] = 1'b1;
                    d.addr[c] = q.addr[c] + 16'h0001;
                    if (q.mode[c][MODE_SEL_LSB +: 2] == SEL_BLOCK)
                        d.blk[c] = 1'b1;
                    // [R1] [R27] count past zero ends session
                    if (q.cnt[c] == 16'h0000) begin
                        tc_set[c] = 1'b1;
                        d.done[c] = 1'b1;
                        d.sreq[c] = 1'b0;
                        d.blk[c] = 1'b0;
                        d.cyc.tc = 1'b1;
                    end else begin
                        d.cnt[c] = q.cnt[c] - 16'h0001;
                    end
                    d.st = ST_DEV;
                end else if (d.st == ST_IDLE) begin
                    for (int i = 0; i < NUM_CH; i++) begin
                        if (!q_rd && sg_enable[i] && q.done[i] &&
                            q.qn[i] != 5'h00) begin
                            q_rd = 1'b1;
                            q_raddr = {2'(i), q.rp[i]};
                            d.ld_ch = 2'(i);
                        end
                    end
                    if (q_rd) d.st = ST_SG_LOAD;
                end
            end
            ST_M2M_RD: begin
                // [R17] [R18] write channel 1, its count rules
                d.cyc.addr = q.addr[1];
                d.cyc.wr = 1'b1;
                d.cyc.wdata = mem_rdata;
                d.addr[1] = q.addr[1] + 16'h0001;
                if (q.cnt[1] == 16'h0000) begin
                    tc_set[1] = 1'b1;
                    d.done[1] = 1'b1;
                    d.sreq[0] = 1'b0;
                    d.cyc.tc = 1'b1;
                end else begin
                    d.cnt[1] = q.cnt[1] - 16'h0001;
                end
                d.st = ST_M2M_WR;
            end
            ST_SG_LOAD: begin
                c = q.ld_ch;
                // [R2] clamp payload, at least one byte
                sz = (sg_size > MAX_PAYLOAD) ? MAX_PAYLOAD : sg_size;
                if (sz == 10'h000) sz = 10'h001;
                // [R3] [R4] packet slot, header skipped
                pa = {1'b1, q_rdata, 2'b00, HDR_BYTES};
                // [R16] external target inside low 32 KB
                ea = {1'b0, q.ext[c]};
                // [R21] program channel without software
                d.cnt[c] = {6'h00, sz - 10'h001};
                d.done[c] = 1'b0;
                d.mask[c] = 1'b0;
                d.rp[c] = q.rp[c] + 4'h1;
                d.qn[c] = d.qn[c] - 5'h01;
                // [R15] [R24] external only on high channels
                d.addr[c] = (sg_memory_operation_bit[c] && c >= 2'h2) ? ea : pa;
                if (sg_memory_operation_bit[c] && c >= 2'h2)
                    d.ext[c] = q.ext[c] + {5'h00, sz};
                if (q.m2m && c == 2'h0) begin
                    // [R23] queued copy, packet and external
                    d.addr[0] = sg_memory_operation_bit[0] ? ea : pa;
                    d.addr[1] = sg_memory_operation_bit[0] ? pa : ea;
                    d.cnt[1] = {6'h00, sz - 10'h001};
                    d.done[1] = 1'b0;
                    d.sreq[0] = 1'b1;
                    d.ext[0] = q.ext[0] + {5'h00, sz};
                end
                d.st = ST_IDLE;
            end
            ST_PIO: begin
                d.pio_ack = 1'b1;
                d.pio_rdata = mem_rdata;
                d.st = ST_IDLE;
            end
            ST_DEV, ST_M2M_WR: d.st = ST_IDLE;
            default: d.st = ST_IDLE;
        endcase
        // Event wins over a clearing read in the same cycle
        d.tc = d.tc | tc_set;
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            q <= '0;
            q.st <= ST_IDLE;
            q.mask <= RST_MASK;
            q.done <= RST_DONE;
        end else begin
            q <= d;
        end
    end

    //------------------------------------------------------------------
    // Queue storage
    //------------------------------------------------------------------
    pkt_queue_mem #(
        .AW (6),
        .DW (PKT_W)
    ) u_queue (
        .sys_clk (sys_clk),
        .wr_en   (q_wr),
        .wr_addr (q_waddr),
        .wr_data (sg_push.pkt),
        .rd_en   (q_rd),
        .rd_addr (q_raddr),
        .rd_data (q_rdata)
    );

    //------------------------------------------------------------------
    // Outputs
    //------------------------------------------------------------------
    // [R10] [R26] shadow is a plain copy of the status bits, so a status read clears it too
    assign bus_stat_tc = q.tc;
    assign reg_rdata = q.rdata;
    assign mem_cyc = q.cyc;
    assign pio_ack = q.pio_ack;
    assign pio_rdata = q.pio_rdata;
    for (genvar g = 0; g < NUM_CH; g++) begin : g_full
        assign sg_full[g] = q.qn[g] == QUEUE_FULL;
    end

    //------------------------------------------------------------------
    // Assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    tc_clear_a: assert property ( // [R25]
        hit && reg_req.rd && ofs == OFS_CMD && tc_set == 4'h0
        |=> bus_stat_tc == 4'h0)
        else $error("status read did not clear terminal counts");
    shadow_rise_a: assert property ( // [R10]
        (bus_stat_tc & ~$past(bus_stat_tc)) != 4'h0 |-> mem_cyc.tc)
        else $error("shadow rose without a terminal cycle");
    hold_quiet_a: assert property ( // [R13]
        bus_hold && q.st == ST_IDLE |=> !mem_cyc.rd && !mem_cyc.wr)
        else $error("cycle started while bus held");
    pkt_addr_a: assert property ( // [R3]
        q.st == ST_SG_LOAD && !sg_memory_operation_bit[q.ld_ch] && !q.m2m
        |=> q.addr[$past(q.ld_ch)][7:0] == 8'h08 &&
            q.addr[$past(q.ld_ch)][15])
        else $error("queued packet address wrong");
    done_stop_a: assert property ( // [R27]
        q.st == ST_IDLE && q.done[2] |=> !mem_cyc.dack[2])
        else $error("finished channel still acknowledged");
    ff_toggle_a: assert property ( // [R7]
        hit && reg_req.wr && ofs <= OFS_CH_LAST |=> q.ff != $past(q.ff))
        else $error("byte pointer did not toggle");
    ff_clear_a: assert property ( // [R6]
        hit && reg_req.wr && ofs == OFS_CLR_FF |=> !q.ff)
        else $error("byte pointer not cleared");
    m2m_seq_a: assert property ( // [R17]
        q.st == ST_M2M_RD |-> mem_cyc.rd &&
            mem_cyc.addr == q.addr[0] - 16'h0001
        ##1 mem_cyc.wr && mem_cyc.wdata == $past(mem_rdata))
        else $error("copy read not followed by write");
    low_ch_pkt_a: assert property ( // [R15]
        mem_cyc.dack[1:0] != 2'h0 |-> mem_cyc.addr[15])
        else $error("low channel reached external memory");
    sg_count_a: assert property ( // [R2]
        q.st == ST_SG_LOAD |=> q.cnt[$past(q.ld_ch)] < 16'h03F8)
        else $error("queued count above payload limit");
    queue_depth_a: assert property ( // [R20]
        q.qn[0] <= QUEUE_FULL && q.qn[3] <= QUEUE_FULL)
        else $error("queue overfilled");

    m2m_done_c: cover property (q.st == ST_M2M_RD ##1 mem_cyc.tc);
    sg_load_c: cover property (q.st == ST_SG_LOAD ##2 mem_cyc.dack != 4'h0);
    pio_c: cover property (pio_req.req ##[1:4] pio_ack);
    block_c: cover property (q.blk[3] ##1 mem_cyc.tc);

endmodule

// file: hdl/pkt_queue_mem.sv
// Packet number queue storage with registered read data
`timescale 1ns/1ps
module pkt_queue_mem #(
    parameter int AW = 6,
    parameter int DW = 5
) (
    // Clock
    input  wire logic          sys_clk,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // Read side
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);

    logic [DW-1:0] mem [2**AW];

    // Contents are undefined until pushed; pointers guard every read
    always_ff @(posedge sys_clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

// file: verif/bus_side_model.sv
// Bus memory and peripheral request model
`timescale 1ns/1ps
module bus_side_model (
    // Clock
    input  wire logic                sys_clk,
    // Controller cycles
    input  wire dma_pkg::mem_cycle_s mem_cyc,
    output logic [7:0]               mem_rdata,
    // Peripheral requests
    input  wire logic [3:0]          want,
    output logic [3:0]               dreq
);
    import dma_pkg::*;
    logic [7:0] mem [0:65535];
    logic [7:0] last_q;
    initial begin
        last_q = 8'h00;
        for (int i = 0; i < 65536; i++) begin
            mem[i] = 8'(i ^ (i >> 8));
        end
    end
    always @(posedge sys_clk) begin
        if (mem_cyc.wr) begin
            mem[mem_cyc.addr] <= mem_cyc.wdata;
        end
        if (mem_cyc.rd) begin
            last_q <= mem[mem_cyc.addr];
        end
    end
    // Released bus shows inverse, never stale data
    assign mem_rdata = mem_cyc.rd ? mem[mem_cyc.addr] : ~last_q;
    assign dreq = want;
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the packet DMA controller
`timescale 1ns/1ps
module tb_top;
    import dma_pkg::*;
    logic        sys_clk = 1'b0;
    logic        sys_rst = 1'b1;
    logic        bus_hold = 1'b1;
    logic [3:0]  want = 4'h0;
    reg_req_s    reg_req = '0;
    sg_push_s    sg_push = '0;
    pio_req_s    pio_req = '0;
    logic [3:0]  sg_enable = 4'h0;
    logic [9:0]  sg_size = 10'h002;
    logic [3:0]  sg_memory_operation_bit = 4'h0;
    logic [14:0] sg_ext_addr = 15'h0000;
    logic [7:0]  reg_rdata, mem_rdata, pio_rdata;
    logic [3:0]  dreq, bus_stat_tc, sg_full;
    logic        pio_ack;
    mem_cycle_s  mem_cyc;
    int          n_errors = 0;
    int          comparisons = 0;
    int          n_tc = 0;
    logic [15:0] seen [$];
    logic [7:0]  prog [8] = '{8'h08, 8'h84, 8'h00, 8'h00,
                              8'h00, 8'h01, 8'h01, 8'h00};

    always #25 sys_clk = ~sys_clk;

    packet_isa_dma_controller i_packet_isa_dma_controller (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .bus_hold(bus_hold), .dreq(dreq),
        .mem_cyc(mem_cyc), .mem_rdata(mem_rdata),
        .bus_stat_tc(bus_stat_tc), .sg_push(sg_push),
        .sg_enable(sg_enable), .sg_memory_operation_bit(sg_memory_operation_bit),
        .sg_ext_addr(sg_ext_addr),
        .sg_size(sg_size), .sg_full(sg_full), .pio_req(pio_req),
        .pio_ack(pio_ack), .pio_rdata(pio_rdata));

    bus_side_model i_bus_side_model (
        .sys_clk(sys_clk), .mem_cyc(mem_cyc), .mem_rdata(mem_rdata),
        .want(want), .dreq(dreq));

    // Every acknowledged byte and every terminal count
    always @(posedge sys_clk) begin
        if (|mem_cyc.dack) begin
            seen.push_back(mem_cyc.addr);
        end
        if (mem_cyc.tc) begin
            n_tc++;
        end
    end

    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8];
    endfunction

    task automatic check(input logic [15:0] s, input logic [15:0] e);
        comparisons++;
        if (s !== e) begin
            n_errors++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask

    task automatic wr(input logic [3:0] ofs, input logic [7:0] d);
        @(posedge sys_clk);
        #5 reg_req = '{wr: 1'b1, rd: 1'b0, addr: CTRL_BASE | 16'(ofs),
                       wdata: d};
        @(posedge sys_clk);
        #5 reg_req = '0;
    endtask

    task automatic rd(input logic [3:0] ofs, input logic [7:0] e);
        @(posedge sys_clk);
        #5 reg_req = '{wr: 1'b0, rd: 1'b1, addr: CTRL_BASE | 16'(ofs),
                       wdata: 8'h00};
        @(posedge sys_clk);
        #5 reg_req = '0;
        check(16'(reg_rdata), 16'(e));
    endtask

    // Bounded wait; late completions surface as a count mismatch
    task automatic wait_tc(input int n);
        for (int k = 0; k < 400 && n_tc < n; k++) begin
            @(posedge sys_clk);
        end
        repeat (2) @(posedge sys_clk);
        #5 check(16'(n_tc), 16'(n));
    endtask

    task automatic conclude;
        if (n_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        #(3000 * 50);
        n_errors++;
        conclude();
    end

    initial begin
        repeat (20) @(posedge sys_clk);
        #5 sys_rst = 1'b0;
        check(16'(bus_stat_tc), 16'h0000);
        wr(OFS_MASK, 8'h07);
        wr(OFS_CLR_FF, 8'h00);
        wr(4'h6, 8'h10);
        wr(4'h6, 8'h11);
        wr(4'h7, 8'h02);
        wr(4'h7, 8'h00);
        wr(OFS_MODE, 8'h4B);
        rd(OFS_CMD, 8'h00);
        wr(OFS_MASK, 8'h03);
        want = 4'h8;
        repeat (10) @(posedge sys_clk);
        #5 check(16'(seen.size()), 16'h0000);
        bus_hold = 1'b0;
        wait_tc(1);
        want = 4'h0;
        check(16'(seen.size()), 16'h0003);
        for (int i = 0; i < 3; i++) check(seen[i], 16'h1110 + 16'(i));
        check(16'(bus_stat_tc[3]), 16'h0001);
        rd(OFS_CMD, 8'h08);
        rd(OFS_CMD, 8'h00);
        // bus held while the copy is set up
        bus_hold = 1'b1;
        wr(OFS_CMD, 8'h01);
        wr(OFS_CLR_FF, 8'h00);
        for (int i = 0; i < 8; i++) wr(4'(i / 2), prog[i]);
        wr(OFS_MODE, 8'h88);
        wr(OFS_MODE, 8'h85);
        wr(OFS_REQ, 8'h04);
        // copy may start only once released
        bus_hold = 1'b0;
        wait_tc(2);
        check(16'(i_bus_side_model.mem[16'h0100]),
              16'(pat(16'h8408)));
        check(16'(i_bus_side_model.mem[16'h0101]),
              16'(pat(16'h8409)));
        check(16'(bus_stat_tc[1]), 16'h0001);
        wr(OFS_CMD, 8'h00);
        for (int i = 0; i < 16; i++) begin
            @(posedge sys_clk);
            #5 sg_push = '{push: 1'b1, ch: 2'h2, pkt: 5'(i)};
        end
        @(posedge sys_clk);
        #5 sg_push = '0;
        check(16'(sg_full), 16'h0004);
        seen.delete();
        want = 4'h4;
        sg_enable = 4'h4;
        wait_tc(4);
        want = 4'h0;
        sg_enable = 4'h0;
        check(seen[0], 16'h8008);
        check(seen[3], 16'h8409);
        pio_req = '{req: 1'b1, wr: 1'b0, addr: 16'h0005, wdata: 8'h00};
        for (int k = 0; k < 50; k++) begin
            @(posedge sys_clk);
            #5 if (pio_ack) break;
        end
        check(16'(pio_rdata), 16'(pat(16'h0005)));
        pio_req = '0;
        // queued packet to external memory on channel 3
        sg_memory_operation_bit = 4'h8;
        sg_ext_addr = 15'h0300;
        @(posedge sys_clk);
        #5 sg_push = '{push: 1'b1, ch: 2'h3, pkt: 5'h01};
        @(posedge sys_clk);
        #5 sg_push = '0;
        seen.delete();
        want = 4'h8;
        sg_enable = 4'h8;
        wait_tc(n_tc + 1);
        check(seen[0], 16'h0300);
        check(16'(seen.size()), 16'h0002);
        conclude();
    end
endmodule
